// ===== common/oag_pkg.sv
// Purpose: constants, modes and helpers for the operand address generator
// Assumes: 8-bit data path, 16-bit address space
// Notes: the flow of one request is described in the main module
// Notes on behaviour
// - every operand carries its own mode, up to three
// - fourteen modes, general 8-bit and extended 16-bit
// - general modes reach register, peripheral, nearby targets
// - register operand byte selects lowest 256 bytes
// - register access one cycle, extended two cycles, indirect extended waits on two memory reads
// - locations zero and one double as A, B
// - peripheral address high byte forced to 10h
// - expansion devices reach external memory via peripheral
// - immediate operand comes from instruction stream
// - implied mode fixes source and destination
// - implied instructions generate no operand address
// - relative base is next instruction address
// - stack relative adds signed byte, eight-bit wrap
// - absolute indexed is B plus 16-bit constant
// - pair gives low byte, register below high
// - offset indirect adds sign-extended byte to pair
`default_nettype none
package oag_pkg;

	typedef enum logic [3:0] {
		M_IMPLIED     = 4'h0,
		M_REGISTER    = 4'h1,
		M_PERIPHERAL  = 4'h2,
		M_IMMEDIATE   = 4'h3,
		M_PC_REL      = 4'h4,
		M_SP_REL      = 4'h5,
		M_ABS_DIRECT  = 4'h6,
		M_ABS_INDEXED = 4'h7,
		M_ABS_INDIR   = 4'h8,
		M_ABS_OFFIND  = 4'h9,
		M_REL_DIRECT  = 4'ha,
		M_REL_INDEXED = 4'hb,
		M_REL_INDIR   = 4'hc,
		M_REL_OFFIND  = 4'hd
	} mode_t;

	localparam logic [7:0] REGFILE_HIGH   = 8'h00;
	localparam logic [7:0] PERIPH_HIGH    = 8'h10;
	localparam logic [1:0] MAX_OP_INDEX   = 2'h2;
	localparam logic [7:0] ONE_BYTE       = 8'h01;
	localparam logic [7:0] EXT_PERIPH_LOW = 8'hc0;

	function automatic logic is_extended(input mode_t m);
		is_extended = (m >= M_ABS_DIRECT) && (m <= M_REL_OFFIND);
	endfunction : is_extended

	function automatic logic is_indirect(input mode_t m);
		is_indirect = (m == M_ABS_INDIR) || (m == M_ABS_OFFIND) ||
			(m == M_REL_INDIR) || (m == M_REL_OFFIND);
	endfunction : is_indirect

	function automatic logic is_relative(input mode_t m);
		is_relative = (m >= M_REL_DIRECT) && (m <= M_REL_OFFIND);
	endfunction : is_relative

	function automatic logic is_valid_mode(input logic [3:0] m);
		is_valid_mode = (m <= 4'hd);
	endfunction : is_valid_mode

	function automatic logic [15:0] sext8(input logic [7:0] v);
		sext8 = {{8{v[7]}}, v};
	endfunction : sext8

endpackage : oag_pkg
`default_nettype wire

// ===== core/ea_adder.sv
// Purpose: plain wrapping adder for effective address sums
// Assumes: unsigned operands, carry discarded
// Notes: used for both base+offset and relative stage
`timescale 1ns/1ps
`default_nettype none
module ea_adder #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] a,
	input  wire logic [WIDTH-1:0] b,
	output logic      [WIDTH-1:0] sum
);
	// carry dropped on purpose
	assign sum = a + b;
endmodule : ea_adder
`default_nettype wire

// ===== core/operand_address_generator.sv
// Purpose: effective address generation for one operand per request
// Assumes: memory read answers with mem_rd_valid, any latency
// Notes: one request at a time, taken only while ready is high
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator #(
	parameter logic [7:0] EXT_PERIPH_LOW = oag_pkg::EXT_PERIPH_LOW
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        req,
	input  wire logic [3:0]  mode,
	input  wire logic [1:0]  op_index,
	input  wire logic [7:0]  operand,
	input  wire logic [15:0] const16,
	input  wire logic [15:0] next_instruction_address,
	input  wire logic [7:0]  stack_pointer,
	input  wire logic [7:0]  reg_b,
	input  wire logic [1:0]  implicit_ab,
	input  wire logic        bus_expansion,
	input  wire logic        mem_rd_valid,
	input  wire logic [7:0]  mem_rd_data,
	output logic             ready,
	output logic             done,
	output logic [15:0]      ea,
	output logic             ea_valid,
	output logic             pc_load,
	output logic             imm_valid,
	output logic [7:0]       imm_data,
	output logic             ext_region,
	output logic [1:0]       op_index_out,
	output logic             mem_rd_req,
	output logic [15:0]      mem_rd_addr
);

	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_EXT = 3'h1, S_HI = 3'h2, S_LO = 3'h3
	} state_t;
	typedef struct packed {
		state_t         state;
		oag_pkg::mode_t mode;
		logic           ready, done, ea_valid, pc_load;
		logic           imm_valid, ext_region, rd_req;
		logic [1:0]     idx;
		logic [7:0]     imm_data, hi, opnd, b;
		logic [15:0]    ea, rd_addr, cval, npc;
	} regs_t;

	regs_t          q, d;
	oag_pkg::mode_t m_s;
	logic [7:0]     op_s, b_s;
	logic [15:0]    c_s, npc_s, base, offs, sum1, rel_add, sum2;
	logic           take;
	// requests beyond the third operand are ignored
	assign take = req && q.ready && (op_index <= oag_pkg::MAX_OP_INDEX) &&
		oag_pkg::is_valid_mode(mode);

	always_comb begin
		m_s   = q.state == S_IDLE ? oag_pkg::mode_t'(mode) : q.mode;
		op_s  = q.state == S_IDLE ? operand : q.opnd;
		c_s   = q.state == S_IDLE ? const16 : q.cval;
		npc_s = q.state == S_IDLE ? next_instruction_address : q.npc;
		b_s   = q.state == S_IDLE ? reg_b : q.b;
		base = '0;
		offs = '0;
		case (m_s)
			oag_pkg::M_PC_REL: begin
				base = npc_s;
				offs = oag_pkg::sext8(op_s);
			end
			oag_pkg::M_SP_REL: begin
				base = {8'h00, stack_pointer};
				offs = oag_pkg::sext8(op_s);
			end
			oag_pkg::M_ABS_DIRECT, oag_pkg::M_REL_DIRECT: begin
				base = c_s;
			end
			oag_pkg::M_ABS_INDEXED, oag_pkg::M_REL_INDEXED: begin
				base = c_s;
				offs = {8'h00, b_s};
			end
			oag_pkg::M_ABS_INDIR, oag_pkg::M_REL_INDIR: begin
				base = {q.hi, mem_rd_data};
			end
			oag_pkg::M_ABS_OFFIND, oag_pkg::M_REL_OFFIND: begin
				base = {q.hi, mem_rd_data};
				offs = oag_pkg::sext8(op_s);
			end
			default: offs = '0;
		endcase
		rel_add = oag_pkg::is_relative(m_s) ? npc_s : 16'h0000;
	end

	ea_adder #(.WIDTH(16)) u_sum (
		.a   (base),
		.b   (offs),
		.sum (sum1)
	);

	ea_adder #(.WIDTH(16)) u_rel (
		.a   (sum1),
		.b   (rel_add),
		.sum (sum2)
	);

	always_comb begin
		d = q;
		d.done = 1'b0;
		d.rd_req = 1'b0;
		case (q.state)
			S_IDLE: begin
				if (take) begin
					d.mode      = m_s;
					d.opnd      = op_s;
					d.cval      = c_s;
					d.npc       = npc_s;
					d.b         = b_s;
					d.idx       = op_index;
					d.ea_valid  = 1'b0;
					d.pc_load   = 1'b0;
					d.imm_valid = 1'b0;
					d.ext_region = 1'b0;
					if (oag_pkg::is_indirect(m_s)) begin
						d.ready   = 1'b0;
						d.state   = S_HI;
						d.rd_req  = 1'b1;
						d.rd_addr = {oag_pkg::REGFILE_HIGH,
							op_s - oag_pkg::ONE_BYTE};
					end else if (oag_pkg::is_extended(m_s)) begin
						d.ready = 1'b0;
						d.state = S_EXT;
					end else begin
						d.done = 1'b1;
						case (m_s)
							oag_pkg::M_REGISTER: begin
								d.ea_valid = 1'b1;
								if (implicit_ab[1]) begin
									d.ea = {15'h0000,
										implicit_ab[0]};
								end else begin
									d.ea = {oag_pkg::REGFILE_HIGH,
										op_s};
								end
							end
							oag_pkg::M_PERIPHERAL: begin
								d.ea_valid = 1'b1;
								d.ea = {oag_pkg::PERIPH_HIGH, op_s};
								d.ext_region = bus_expansion &&
									(op_s >= EXT_PERIPH_LOW);
							end
							oag_pkg::M_IMMEDIATE: begin
								d.imm_valid = 1'b1;
								d.imm_data  = op_s;
							end
							oag_pkg::M_PC_REL: begin
								d.ea_valid = 1'b1;
								d.pc_load  = 1'b1;
								d.ea       = sum1;
							end
							oag_pkg::M_SP_REL: begin
								d.ea_valid = 1'b1;
								d.ea = {oag_pkg::REGFILE_HIGH,
									sum1[7:0]};
							end
							default: begin
								// implied: fixed by the instruction
								d.ea_valid = 1'b0;
							end
						endcase
					end
				end
			end
			S_EXT: begin
				d.done     = 1'b1;
				d.ready    = 1'b1;
				d.state    = S_IDLE;
				d.ea_valid = 1'b1;
				d.ea       = sum2;
				d.pc_load  = oag_pkg::is_relative(q.mode);
			end
			S_HI: begin
				if (mem_rd_valid) begin
					d.hi      = mem_rd_data;
					d.rd_req  = 1'b1;
					d.rd_addr = {oag_pkg::REGFILE_HIGH, q.opnd};
					d.state   = S_LO;
				end
			end
			S_LO: begin
				if (mem_rd_valid) begin
					d.done     = 1'b1;
					d.ready    = 1'b1;
					d.state    = S_IDLE;
					d.ea_valid = 1'b1;
					d.ea       = sum2;
					d.pc_load  = oag_pkg::is_relative(q.mode);
				end
			end
			default: begin
				d.state = S_IDLE;
				d.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			q       <= '0;
			q.state <= S_IDLE;
			q.ready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign ready        = q.ready;
	assign done         = q.done;
	assign ea           = q.ea;
	assign ea_valid     = q.ea_valid;
	assign pc_load      = q.pc_load;
	assign imm_valid    = q.imm_valid;
	assign imm_data     = q.imm_data;
	assign ext_region   = q.ext_region;
	assign op_index_out = q.idx;
	assign mem_rd_req   = q.rd_req;
	assign mem_rd_addr  = q.rd_addr;

	sequence s_ext_req;
		take && oag_pkg::is_extended(oag_pkg::mode_t'(mode)) &&
			!oag_pkg::is_indirect(oag_pkg::mode_t'(mode));
	endsequence
	sequence s_two_cycle;
		!done ##1 done;
	endsequence

	property p_general_one;
		@(posedge clock) disable iff (srst)
		take && !oag_pkg::is_extended(oag_pkg::mode_t'(mode)) |-> ##1 done;
	endproperty
	a_general_one: assert property (p_general_one)
		else $error("general mode did not finish in one cycle");
	property p_ext_two;
		@(posedge clock) disable iff (srst)
		s_ext_req |-> ##1 s_two_cycle;
	endproperty
	a_ext_two: assert property (p_ext_two)
		else $error("extended mode did not take two cycles");
	property p_periph;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_PERIPHERAL |->
			##1 ea == {oag_pkg::PERIPH_HIGH, $past(operand)};
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral address wrong");
	property p_implied;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_IMPLIED |-> ##1 (done && !ea_valid);
	endproperty
	a_implied: assert property (p_implied)
		else $error("implied mode produced an address");
	property p_pc_rel;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_PC_REL |-> ##1 (pc_load &&
			ea == 16'($past(next_instruction_address) +
			oag_pkg::sext8($past(operand))));
	endproperty
	a_pc_rel: assert property (p_pc_rel)
		else $error("pc relative target wrong");
	property p_sp_rel;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_SP_REL |-> ##1
			ea == {8'h00, 8'($past(stack_pointer) + $past(operand))};
	endproperty
	a_sp_rel: assert property (p_sp_rel)
		else $error("stack relative address wrong");
	property p_indexed;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_ABS_INDEXED |-> ##2
			ea == 16'($past(const16, 2) + {8'h00, $past(reg_b, 2)});
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("indexed address wrong");
	property p_pair_hi;
		@(posedge clock) disable iff (srst)
		take && oag_pkg::is_indirect(oag_pkg::mode_t'(mode)) |-> ##1
			(mem_rd_req && mem_rd_addr == {8'h00, 8'($past(operand) - 8'h01)});
	endproperty
	a_pair_hi: assert property (p_pair_hi)
		else $error("pair high byte read from wrong register");
	property p_rel_load;
		@(posedge clock) disable iff (srst)
		take && mode == oag_pkg::M_REL_DIRECT |-> ##2 (pc_load && ea ==
			16'($past(const16, 2) + $past(next_instruction_address, 2)));
	endproperty
	a_rel_load: assert property (p_rel_load)
		else $error("relative direct target wrong");
endmodule : operand_address_generator
`default_nettype wire

// ===== dv/memory_responder.sv
// Purpose: memory model answering the generator's byte reads
// Assumes: one read outstanding at a time
// Notes: slow adds four wait cycles; data line churns when idle
`timescale 1ns/1ps
`default_nettype none
module memory_responder (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        slow,
	input  wire logic        mem_rd_req,
	input  wire logic [15:0] mem_rd_addr,
	output logic             mem_rd_valid,
	output logic [7:0]       mem_rd_data
);
	logic        pend = 1'b0;
	logic [2:0]  cnt = 3'h0;
	logic [15:0] addr = 16'h0000;

	initial mem_rd_valid = 1'b0;
	initial mem_rd_data = 8'h00;

	function automatic logic [7:0] byte_at(input logic [7:0] a);
		return a * 8'h3b ^ 8'ha5;
	endfunction : byte_at

	always @(posedge clock) begin
		mem_rd_valid <= 1'b0;
		// stale data never looks valid
		mem_rd_data <= ~mem_rd_data;
		if (srst) begin
			pend <= 1'b0;
		end else if (mem_rd_req) begin
			pend <= 1'b1;
			addr <= mem_rd_addr;
			cnt <= slow ? 3'h4 : 3'h0;
		end else if (pend && cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end else if (pend) begin
			pend <= 1'b0;
			mem_rd_valid <= 1'b1;
			mem_rd_data <= byte_at(addr[7:0]);
		end
	end
endmodule : memory_responder
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for the operand address generator
// Assumes: inputs change 1 ns after the rising edge
// Notes: req stays up between operations for back-to-back takes
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        req = 1'b0;
	logic        bus_expansion = 1'b0;
	logic        slow = 1'b0;
	logic [3:0]  mode = 4'h0;
	logic [1:0]  op_index = 2'h0;
	logic [1:0]  implicit_ab = 2'h0;
	logic [7:0]  operand = 8'h00;
	logic [7:0]  stack_pointer = 8'h00;
	logic [7:0]  reg_b = 8'h00;
	logic [15:0] const16 = 16'h0000;
	logic [15:0] next_instruction_address = 16'h0000;
	logic [31:0] rng = 32'hda0c6108;
	logic [31:0] r;
	wire logic   mem_rd_valid, ready, done, ea_valid, pc_load;
	wire logic   imm_valid, ext_region, mem_rd_req;
	wire logic [7:0]  mem_rd_data, imm_data;
	wire logic [15:0] ea, mem_rd_addr;
	wire logic [1:0]  op_index_out;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	operand_address_generator operand_address_generator_i (
		.clock(clock), .srst(srst), .req(req), .mode(mode),
		.op_index(op_index), .operand(operand), .const16(const16),
		.next_instruction_address(next_instruction_address),
		.stack_pointer(stack_pointer), .reg_b(reg_b),
		.implicit_ab(implicit_ab), .bus_expansion(bus_expansion),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.ready(ready), .done(done), .ea(ea), .ea_valid(ea_valid),
		.pc_load(pc_load), .imm_valid(imm_valid), .imm_data(imm_data),
		.ext_region(ext_region), .op_index_out(op_index_out),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr));

	memory_responder memory_responder_i (
		.clock(clock), .srst(srst), .slow(slow), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data));

	initial begin
		forever #2.5 clock = ~clock;
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	function automatic logic [7:0] mem_byte(input logic [7:0] a);
		return a * 8'h3b ^ 8'ha5;
	endfunction : mem_byte

	function automatic logic [15:0] exp_ea(input logic [3:0] m);
		logic [15:0] pair;
		logic [15:0] v;
		pair = {mem_byte(operand - 8'h01), mem_byte(operand)};
		case (m)
			4'h1: v = implicit_ab[1] ? {15'h0000, implicit_ab[0]}
				: {8'h00, operand};
			4'h2: v = {8'h10, operand};
			4'h4: v = next_instruction_address + {{8{operand[7]}}, operand};
			4'h5: v = {8'h00, stack_pointer + operand};
			4'h6, 4'ha: v = const16;
			4'h7, 4'hb: v = const16 + {8'h00, reg_b};
			4'h8, 4'hc: v = pair;
			4'h9, 4'hd: v = pair + {{8{operand[7]}}, operand};
			default: v = 16'h0000;
		endcase
		if (m >= 4'ha) v = v + next_instruction_address;
		return v;
	endfunction : exp_ea

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic final_report();
		if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report

	// fix[8] pins operand to fix[7:0] and forces wrapping bases
	task automatic run(input logic [3:0] m, input logic [1:0] oi,
		input logic [8:0] fix);
		int n;
		r = xs();
		mode = m;
		op_index = oi;
		operand = fix[8] ? fix[7:0] : r[7:0];
		stack_pointer = r[15:8];
		reg_b = fix[8] ? 8'hff : r[23:16];
		implicit_ab = r[25:24];
		bus_expansion = fix[8] | r[26];
		slow = r[27];
		r = xs();
		const16 = fix[8] ? 16'hffff : r[15:0];
		next_instruction_address = fix[8] ? 16'hff80 : r[31:16];
		req = 1'b1;
		@(posedge clock);
		#1;
		n = 1;
		if (m > 4'h5) chk("busy ready", ready, 1'b0);
		while (done !== 1'b1 && n < 60) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (m <= 4'h5) chk("latency", n[15:0], 16'h1);
		else if (!m[3] || m[1]) chk("latency", n[15:0], 16'h2);
		else chk("indirect wait", n[15:0], slow ? 16'hf : 16'h7);
		chk("ready", ready, 1'b1);
		chk("op_index_out", op_index_out, oi);
		chk("ea_valid", ea_valid, m != 0 && m != 3);
		chk("pc_load", pc_load, m == 4 || m >= 4'ha);
		chk("imm_valid", imm_valid, m == 3);
		if (m == 3) chk("imm_data", imm_data, operand);
		if (m == 2) chk("ext_region", ext_region,
			bus_expansion && operand >= oag_pkg::EXT_PERIPH_LOW);
		if (m != 0 && m != 3) chk("ea", ea, exp_ea(m));
	endtask : run

	task automatic refuse(input logic [3:0] m, input logic [1:0] oi);
		mode = m;
		op_index = oi;
		req = 1'b1;
		repeat (3) begin
			@(posedge clock);
			#1;
			chk("refused done", done, 0);
			chk("refused ready", ready, 1'b1);
		end
	endtask : refuse

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		#1;
		srst = 1'b0;
		for (int m = 0; m < 14; m++) run(4'(m), 2'(m % 3), 9'h000);
		// wrap and sign corners
		run(4'h8, 2'h0, 9'h100);
		run(4'hd, 2'h1, 9'h180);
		run(4'h2, 2'h2, 9'h1c0);
		run(4'h2, 2'h2, 9'h1bf);
		run(4'h5, 2'h0, 9'h180);
		run(4'hb, 2'h1, 9'h1ff);
		run(4'h4, 2'h0, 9'h17f);
		refuse(4'h1, 2'h3);
		refuse(4'he, 2'h0);
		refuse(4'hf, 2'h1);
		repeat (300) begin
			r = xs();
			run(4'(r[3:0] % 4'he), 2'(r[5:4] % 2'h3), 9'h000);
		end
		req = 1'b0;
		final_report();
	end
endmodule : testbench
`default_nettype wire
